// [src/brc_pkg.sv]
// Constants and types for the bidirectional reset sequencer.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone bus.
package brc_pkg;

   // ==========================================================
   // Timing
   localparam int          CLK_PERIOD_NS     = 25;
   localparam int          RESET_INPUT_PIN_MIN_NS      = 100;
   // Least low time of the reset pin: 100 ns rounded up, plus 2 clocks
   localparam int          RESET_INPUT_PIN_FILT_CYCLES = (RESET_INPUT_PIN_MIN_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS + 2;
   localparam logic [2:0]  FILT_LAST         = 3'(RESET_INPUT_PIN_FILT_CYCLES - 1);
   localparam int          RESET_SEQ_CYCLES  = 1024;
   localparam logic [10:0] SEQ_LAST          = 11'(RESET_SEQ_CYCLES - 1);

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_FLAGS  = 8'h04;
   localparam logic [7:0] ADR_IRQ_ST = 8'h08;
   localparam logic [7:0] ADR_IRQ_MK = 8'h0C;
   localparam logic [7:0] ADR_STRAP  = 8'h10;

   // Field positions
   localparam int CTRL_BDEN_BIT  = 0;
   localparam int CTRL_SWRST_BIT = 1;
   localparam int FLAGS_INIT_BIT = 4;
   localparam int FLAGS_BOOT_BIT = 5;
   localparam int FLAGS_BDA_BIT  = 6;
   localparam int BOOT_STRAP_BIT = 4;

   // Reset values
   localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
   localparam logic [15:0] STRAP_RST    = 16'hFFFF;

   // Reset source flags, also the layout of the interrupt registers
   typedef struct packed {
      logic wdt;
      logic sw;
      logic short_hw;
      logic long_hw;
   } brc_flags_t;

   localparam brc_flags_t FLAGS_LONG_HW = '{wdt: 1'b0, sw: 1'b0,
                                           short_hw: 1'b0, long_hw: 1'b1};

   // Sequencer states
   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_SEQ  = 3'b010,
      ST_HOLD = 3'b100
   } brc_state_t;

endpackage : brc_pkg

// [src/brc_reset_ctrl.sv]
// Reset sequencer with optional bidirectional reset pin.
// Assumes the reset pin and strap port arrive asynchronously, and that the
// core pulses eoi_i, sw_reset_i and wdt_reset_i for one clock each.
//
// Contract
// - The bidirectional enable locks after end of init and clears on every reset.
// - With bidirectional reset active, the source flags always show a long hardware reset.
// - With bidirectional reset active, every reset samples and applies the straps.
// - With bidirectional reset active, a low boot select strap selects the boot loader.
// - With bidirectional reset active, a short hardware reset lasts the full sequence.
// - With bidirectional reset active, the block pulls the pin low for the whole sequence.
// - The reset indication output is low from any reset until end of init.
// - A low reset pin puts the device into reset.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
module brc_reset_ctrl
   import brc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Core events
   input  wire logic        eoi_i,
   input  wire logic        sw_reset_i,
   input  wire logic        wdt_reset_i,
   // Open-drain reset pin
   input  wire logic        reset_input_pin_i,
   output logic             reset_input_pin_o,
   output logic             reset_input_pin_oe_n_o,
   // Straps and results
   input  wire logic [15:0] config_strap_port_i,
   output logic      [15:0] strap_cfg_o,
   output logic             boot_loader_o,
   output logic             core_reset_o,
   output logic             reset_indication_output_o,
   output logic             irq_o
);

   // ==========================================================
   // Declarations
   brc_state_t  state;
   logic [10:0] seq_cnt;
   logic [2:0]  filt_cnt;
   logic [1:0]  pin_sync;
   logic [15:0] strap_meta;
   logic [15:0] strap_sync;
   logic        pin_s;
   logic        bidir_reset_enable;
   logic        bidir_active;
   logic        init_done;
   logic        cause_hw;
   logic        cause_sw;
   brc_flags_t  flags;
   brc_flags_t  next_flags;
   brc_flags_t  irq_stat;
   brc_flags_t  irq_mask;
   logic        pin_trig;
   logic        sw_req;
   logic        seq_start;
   logic        seq_end;
   logic        wb_wr;
   logic        wb_rd;

   // ==========================================================
   // Input synchronisers
   // Two flops before any logic looks at pin or straps
   always_ff @(posedge clk_i) begin
      pin_sync   <= {pin_sync[0], reset_input_pin_i};
      strap_meta <= config_strap_port_i;
      strap_sync <= strap_meta;
   end

   assign pin_s = pin_sync[1];

   // Low-time filter on the pin; runs only while the core is running, so the
   // block never sees its own drive as a new request
   always_ff @(posedge clk_i) begin
      if (rst_i || state != ST_RUN || pin_s) begin
         filt_cnt <= 3'h0;
      end else if (filt_cnt != FILT_LAST) begin
         filt_cnt <= filt_cnt + 3'h1;
      end
   end

   // ==========================================================
   // Reset requests
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
   assign wb_rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   assign pin_trig = !pin_s && filt_cnt == FILT_LAST;
   assign sw_req = sw_reset_i || (wb_wr && wb_adr_i == ADR_CTRL && wb_sel_i[0]
                   && wb_dat_i[CTRL_SWRST_BIT]);
   assign seq_start = state == ST_RUN && (pin_trig || sw_req || wdt_reset_i);
   assign seq_end = state == ST_SEQ && seq_cnt == SEQ_LAST;

   // ==========================================================
   // Sequencer
   // Every reset runs the full count, so a short pin pulse is stretched
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= ST_SEQ;
         seq_cnt <= 11'h000;
      end else begin
         unique case (state)
            ST_RUN: begin
               seq_cnt <= 11'h000;
               if (seq_start) begin
                  state <= ST_SEQ;
               end
            end
            ST_SEQ: begin
               if (seq_end) begin
                  state <= ST_HOLD;
               end else begin
                  seq_cnt <= seq_cnt + 11'h001;
               end
            end
            ST_HOLD: begin
               // Waits out pin sync lag and any long external pull
               if (pin_s) begin
                  state <= ST_RUN;
               end
            end
         endcase
      end
   end

   assign core_reset_o = state != ST_RUN;

   // Pin is only ever pulled low; high level comes from the pull-up
   assign reset_input_pin_o = 1'b0;
   assign reset_input_pin_oe_n_o = !(state == ST_SEQ && bidir_active);

   // ==========================================================
   // Mode enable and init state
   // Mode taken at reset start; the enable itself is wiped by that reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bidir_active <= 1'b0;
      end else if (seq_start) begin
         bidir_active <= bidir_reset_enable;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || seq_start) begin
         bidir_reset_enable <= 1'b0;
      end else if (wb_wr && wb_adr_i == ADR_CTRL && wb_sel_i[0] && !init_done) begin
         bidir_reset_enable <= wb_dat_i[CTRL_BDEN_BIT];
      end
   end

   // Indication output tracks init state directly
   always_ff @(posedge clk_i) begin
      if (rst_i || seq_start) begin
         init_done <= 1'b0;
      end else if (eoi_i && state == ST_RUN) begin
         init_done <= 1'b1;
      end
   end

   assign reset_indication_output_o = init_done;

   // ==========================================================
   // Reset cause and source flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_hw <= 1'b1;
         cause_sw <= 1'b0;
      end else if (seq_start) begin
         cause_hw <= pin_trig;
         cause_sw <= !pin_trig && !wdt_reset_i;
      end
   end

   // Own drive hides the pin, so short and long cannot be told apart
   always_comb begin
      next_flags = '0;
      if (bidir_active) begin
         next_flags = FLAGS_LONG_HW;
      end else if (cause_hw) begin
         next_flags.long_hw  = !pin_s;
         next_flags.short_hw = pin_s;
      end else if (cause_sw) begin
         next_flags.sw = 1'b1;
      end else begin
         next_flags.wdt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= FLAGS_LONG_HW;
      end else if (seq_end) begin
         flags <= next_flags;
      end
   end

   // ==========================================================
   // Strap capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_cfg_o   <= STRAP_RST;
         boot_loader_o <= 1'b0;
      end else if (seq_end && (bidir_active || cause_hw)) begin
         strap_cfg_o   <= strap_sync;
         boot_loader_o <= !strap_sync[BOOT_STRAP_BIT];
      end
   end

   // ==========================================================
   // Interrupts
   // Set beats a write-one clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~((wb_wr && wb_adr_i == ADR_IRQ_ST && wb_sel_i[0])
                     ? brc_flags_t'(wb_dat_i[3:0]) : brc_flags_t'(4'h0)))
                     | (seq_end ? next_flags : brc_flags_t'(4'h0));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= IRQ_MASK_RST;
      end else if (wb_wr && wb_adr_i == ADR_IRQ_MK && wb_sel_i[0]) begin
         irq_mask <= wb_dat_i[3:0];
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // ==========================================================
   // Wishbone slave
   // One wait state; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_rd) begin
         unique case (wb_adr_i)
            ADR_CTRL:   wb_dat_o <= {31'h0, bidir_reset_enable};
            ADR_FLAGS:  wb_dat_o <= {25'h0, bidir_active, boot_loader_o,
                                     init_done, flags};
            ADR_IRQ_ST: wb_dat_o <= {28'h0, irq_stat};
            ADR_IRQ_MK: wb_dat_o <= {28'h0, irq_mask};
            ADR_STRAP:  wb_dat_o <= {16'h0, strap_cfg_o};
            default:    wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Checks
   a_enable_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      (init_done && !seq_start) |=> $stable(bidir_reset_enable))
      else $error("enable changed after end of init");

   a_enable_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_start |=> !bidir_reset_enable)
      else $error("enable not cleared by reset");

   a_flags_long: assert property (@(posedge clk_i) disable iff (rst_i)
      (seq_end && bidir_active) |=> flags == FLAGS_LONG_HW)
      else $error("flags not long hardware reset");

   a_strap_apply: assert property (@(posedge clk_i) disable iff (rst_i)
      (seq_end && bidir_active) |=> strap_cfg_o == $past(strap_sync))
      else $error("straps not applied");

   a_boot_select: assert property (@(posedge clk_i) disable iff (rst_i)
      (seq_end && bidir_active) |=> boot_loader_o == !$past(strap_sync[BOOT_STRAP_BIT]))
      else $error("boot select wrong");

   a_reset_stretch: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_start |=> core_reset_o [*8] ##0 (seq_cnt == 11'h007))
      else $error("reset sequence cut short");

   a_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      (seq_start && bidir_reset_enable) |=> !reset_input_pin_oe_n_o [*8])
      else $error("pin not pulled low");

   a_indication_low: assert property (@(posedge clk_i) disable iff (rst_i)
      (!reset_indication_output_o && !(eoi_i && state == ST_RUN))
      |=> !reset_indication_output_o)
      else $error("indication rose without end of init");

   a_pin_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_RUN && !pin_s && filt_cnt == FILT_LAST) |=> state == ST_SEQ)
      else $error("low pin did not reset");

   // Own count of held cycles, kept apart from the sequencer so the check
   // does not lean on the counter that it guards
   logic [10:0] held_cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i || seq_start) begin
         held_cnt <= 11'h000;
      end else if (core_reset_o && held_cnt != 11'(RESET_SEQ_CYCLES)) begin
         held_cnt <= held_cnt + 11'h001;
      end
   end

   a_stretch_full: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> held_cnt == 11'(RESET_SEQ_CYCLES))
      else $error("reset released before full sequence");

endmodule : brc_reset_ctrl

// [verification/brc_ext_reset_model.sv]
// External reset source sharing the open-drain reset pin.
// Assumes the bench resolves the pin with a pull-up and this model's pull_n_o.
module brc_ext_reset_model (
   // Clock and command
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic [7:0] len_i,
   // Open-drain pull, low pulls the pin
   output logic            pull_n_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // ============================================================
   // Pull counter
   logic [7:0] left = 8'h00;

   // Pulls low for len_i cycles, then only lets go, never drives high
   always_ff @(posedge clk_i) begin
      if (start_i) begin
         left <= len_i;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign pull_n_o = (left == 8'h00);
endmodule : brc_ext_reset_model

// [verification/brc_reset_ctrl_tb_top.sv]
// Self-checking bench for the reset sequencer.
// Assumes brc_pkg and the sequencer are compiled first; one 40 MHz clock.
module brc_reset_ctrl_tb_top;
   timeunit 1ns;
   // Finer than the unit so the 12.5 ns half period is not rounded to 13 ns
   timeprecision 100ps;
   import brc_pkg::*;

   // ============================================================
   // Signals
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat, q;
   logic        ack, eoi = 1'b0, swr = 1'b0, wdr = 1'b0, pin_o, oe_n, pull_n, pin_w;
   logic        ext_go = 1'b0, boot, core_rst, ind, irq;
   logic [15:0] straps = 16'hFFFF, cfg;
   int          n_errors = 0, samples_checked = 0, cycles = 0;

   always #12.5 clk_i = ~clk_i;
   // Pull-up on the shared pin; either party may only pull it low
   assign pin_w = (oe_n ? 1'b1 : pin_o) & pull_n;

   brc_reset_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .eoi_i(eoi), .sw_reset_i(swr), .wdt_reset_i(wdr),
      .reset_input_pin_i(pin_w), .reset_input_pin_o(pin_o),
      .reset_input_pin_oe_n_o(oe_n), .config_strap_port_i(straps), .strap_cfg_o(cfg),
      .boot_loader_o(boot), .core_reset_o(core_rst),
      .reset_indication_output_o(ind), .irq_o(irq));
   brc_ext_reset_model ext (.clk_i(clk_i), .start_i(ext_go), .len_i(8'h08),
      .pull_n_o(pull_n));

   // ============================================================
   // Tasks
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // Classic single cycle; waits for ack, then releases for an idle cycle
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb

   task automatic wait_run;
      int n;
      n = 0;
      while (core_rst !== 1'b0 && n < 3000) begin
         tick(1);
         n++;
      end
      chk("core_reset_o", 32'h0, {31'h0, core_rst});
   endtask : wait_run

   // Guards against a hang anywhere in the sequence
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   // ============================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_run();
      wb(ADR_IRQ_MK, 1'b0, 32'h0); chk("mask", {28'h0, IRQ_MASK_RST}, q);
      wb(8'h14, 1'b0, 32'h0); chk("unmapped", 32'h0, q);
      // Power-on leaves the pin high at sequence end, so it reads as a short pull
      wb(ADR_FLAGS, 1'b0, 32'h0); chk("flags", 32'h2, q & 32'hF);
      wb(ADR_IRQ_ST, 1'b1, 32'hF);
      wb(ADR_IRQ_ST, 1'b0, 32'h0); chk("status", 32'h0, q);
      wb(ADR_CTRL, 1'b1, 32'h1);
      wb(ADR_CTRL, 1'b0, 32'h0); chk("ctrl", 32'h1, q);
      // Short pull by the far side, stretched to the whole sequence
      straps <= 16'h5A1F;
      @(posedge clk_i) ext_go <= 1'b1;
      @(posedge clk_i) ext_go <= 1'b0;
      tick(40);
      chk("pin", 32'h0, {31'h0, pin_w});
      chk("core_reset_o", 32'h1, {31'h0, core_rst});
      tick(900);
      chk("core_reset_o", 32'h1, {31'h0, core_rst});
      wait_run();
      wb(ADR_FLAGS, 1'b0, 32'h0); chk("flags", 32'h41, q & 32'h6F);
      wb(ADR_CTRL, 1'b0, 32'h0); chk("ctrl", 32'h0, q);
      // Software reset in bidirectional mode with boot select low
      wb(ADR_CTRL, 1'b1, 32'h1);
      straps <= 16'hA5E5;
      tick(4);
      @(posedge clk_i) swr <= 1'b1;
      @(posedge clk_i) swr <= 1'b0;
      #1;
      chk("indication", 32'h0, {31'h0, ind});
      chk("oe_n", 32'h0, {31'h0, oe_n});
      wait_run();
      chk("strap_cfg_o", 32'hA5E5, {16'h0, cfg});
      chk("boot_loader_o", 32'h1, {31'h0, boot});
      wb(ADR_FLAGS, 1'b0, 32'h0); chk("flags", 32'h61, q & 32'h6F);
      // Interrupt raised, masked and cleared
      wb(ADR_IRQ_MK, 1'b1, 32'h1);
      tick(1); chk("irq_o", 32'h1, {31'h0, irq});
      wb(ADR_IRQ_MK, 1'b1, 32'h0);
      tick(1); chk("irq_o", 32'h0, {31'h0, irq});
      wb(ADR_IRQ_ST, 1'b1, 32'h1);
      wb(ADR_IRQ_ST, 1'b0, 32'h0); chk("status", 32'h0, q);
      // End of init, then the enable is locked
      @(posedge clk_i) eoi <= 1'b1;
      @(posedge clk_i) eoi <= 1'b0;
      tick(2); chk("indication", 32'h1, {31'h0, ind});
      wb(ADR_CTRL, 1'b1, 32'h1);
      wb(ADR_CTRL, 1'b0, 32'h0); chk("ctrl", 32'h0, q);
      // Watchdog reset outside bidirectional mode keeps its own cause
      @(posedge clk_i) wdr <= 1'b1;
      @(posedge clk_i) wdr <= 1'b0;
      tick(2); chk("oe_n", 32'h1, {31'h0, oe_n});
      chk("indication", 32'h0, {31'h0, ind});
      wait_run();
      wb(ADR_FLAGS, 1'b0, 32'h0); chk("flags", 32'h8, q & 32'hF);
      // Software reset through the control register, outside bidirectional mode
      wb(ADR_CTRL, 1'b1, 32'h2);
      tick(2); chk("core_reset_o", 32'h1, {31'h0, core_rst});
      chk("oe_n", 32'h1, {31'h0, oe_n});
      wait_run();
      wb(ADR_FLAGS, 1'b0, 32'h0); chk("flags", 32'h4, q & 32'h4F);
      end_sim();
   end
endmodule : brc_reset_ctrl_tb_top
